// >>> include/charger_cfg_pkg.sv
// Shared constants and types for the charger configuration register bank
package charger_cfg_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] PRECHG_TERM_OFFSET = 8'h1A;
	localparam logic [7:0] THERM_SYSV_OFFSET = 8'h1B;
	localparam logic [7:0] PRECHG_TERM_RESET = 8'hF8;
	localparam logic [7:0] THERM_SYSV_RESET = 8'h10;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PREQUAL_LSB = 5;
	localparam int TERM_LSB = 3;
	localparam int TOPOFF_LSB = 0;
	localparam int DIE_TEMP_LSB = 5;
	localparam int SYSV_LSB = 0;

	// ************************************************************
	// Decode figures
	// ************************************************************
	localparam logic [11:0] PREQUAL_BASE_MV = 12'h08FC;
	localparam logic [11:0] PREQUAL_STEP_MV = 12'h0064;
	localparam logic [7:0] TERM_CODE0_PCT_X10 = 8'h32;
	localparam logic [7:0] TERM_CODE1_PCT_X10 = 8'h4B;
	localparam logic [7:0] TERM_CODE2_PCT_X10 = 8'h64;
	localparam logic [7:0] TERM_CODE3_PCT_X10 = 8'h96;
	localparam logic [5:0] TOPOFF_STEP_MIN = 6'h05;
	localparam logic [6:0] DIE_TEMP_BASE_C = 7'h3C;
	localparam logic [6:0] DIE_TEMP_STEP_C = 7'h0A;
	localparam logic [2:0] DIE_TEMP_SAT_CODE = 3'h4;
	localparam logic [6:0] DIE_TEMP_MAX_C = 7'h64;
	localparam logic [12:0] SYSV_BASE_MV = 13'h1004;
	localparam logic [12:0] SYSV_STEP_MV = 13'h0019;
	localparam logic [4:0] SYSV_SAT_CODE = 5'h1C;
	localparam logic [12:0] SYSV_MAX_MV = 13'h12C0;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [11:0] prequal_mv;
		logic [7:0] term_pct_x10;
		logic [5:0] topoff_min;
		logic [6:0] die_temp_c;
		logic [12:0] sysv_mv;
	} charger_settings_t;

	typedef struct packed {
		logic [2:0] prequal_voltage_sel;
		logic [1:0] term_sel;
		logic [2:0] topoff_sel;
		logic [2:0] die_temp_regulation_sel;
		logic [4:0] system_voltage_target;
	} charger_fields_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b0_0001,
		ST_RX = 5'b0_0010,
		ST_ACK_OUT = 5'b0_0100,
		ST_TX = 5'b0_1000,
		ST_ACK_IN = 5'b1_0000
	} i2c_state_t;

	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_PTR = 2'b01,
		PH_DATA = 2'b10
	} i2c_phase_t;

endpackage : charger_cfg_pkg

// >>> core/charger_field_decode.sv
// Decoder from raw register fields to charger analog settings
`timescale 1ns/1ps

module charger_field_decode (
	// Raw fields
	input wire charger_cfg_pkg::charger_fields_t fields_i,
	// Decoded settings
	output charger_cfg_pkg::charger_settings_t settings_o
);

	// ************************************************************
	// Lookup for termination current
	// ************************************************************
	function automatic logic [7:0] term_lookup(input logic [1:0] code);
		logic [7:0] pct;
		pct = charger_cfg_pkg::TERM_CODE0_PCT_X10;
		case (code)
			2'h1: pct = charger_cfg_pkg::TERM_CODE1_PCT_X10;
			2'h2: pct = charger_cfg_pkg::TERM_CODE2_PCT_X10;
			2'h3: pct = charger_cfg_pkg::TERM_CODE3_PCT_X10;
			default: pct = charger_cfg_pkg::TERM_CODE0_PCT_X10;
		endcase
		return pct;
	endfunction : term_lookup

	// Named intermediate products
	wire [11:0] prequal_mv;
	wire [6:0] die_temp_lin;
	wire [12:0] sysv_lin;
	wire die_temp_sat;
	wire sysv_sat;

	// Linear steps; both saturating fields clamp from their saturation code up (die temp code 4, system voltage code 28)
	assign prequal_mv = charger_cfg_pkg::PREQUAL_BASE_MV
		+ 12'(charger_cfg_pkg::PREQUAL_STEP_MV * 12'(fields_i.prequal_voltage_sel));
	assign die_temp_lin = charger_cfg_pkg::DIE_TEMP_BASE_C
		+ 7'(charger_cfg_pkg::DIE_TEMP_STEP_C * 7'(fields_i.die_temp_regulation_sel));
	assign die_temp_sat = fields_i.die_temp_regulation_sel >= charger_cfg_pkg::DIE_TEMP_SAT_CODE;
	assign sysv_lin = charger_cfg_pkg::SYSV_BASE_MV
		+ 13'(charger_cfg_pkg::SYSV_STEP_MV * 13'(fields_i.system_voltage_target));
	assign sysv_sat = fields_i.system_voltage_target >= charger_cfg_pkg::SYSV_SAT_CODE;

	// Settings bundle
	assign settings_o.prequal_mv = prequal_mv;
	assign settings_o.term_pct_x10 = term_lookup(fields_i.term_sel);
	assign settings_o.topoff_min = 6'(charger_cfg_pkg::TOPOFF_STEP_MIN
		* 6'(fields_i.topoff_sel));
	assign settings_o.die_temp_c = die_temp_sat ? charger_cfg_pkg::DIE_TEMP_MAX_C
		: die_temp_lin;
	assign settings_o.sysv_mv = sysv_sat ? charger_cfg_pkg::SYSV_MAX_MV : sysv_lin;

endmodule : charger_field_decode

// >>> core/charger_config_regs.sv
// Charger configuration registers behind an I2C target port
`timescale 1ns/1ps

// Contract
// - Both registers read/write over I2C, strap-selected address
// - Offset 0x1A resets to 0xF8, all bits RW
// - Offset 0x1B resets to 0x10, all bits RW
// - 0x1A[7:5] prequal threshold 2.3V plus 0.1V/code
// - 0x1A[4:3] termination 5, 7.5, 10, 15 percent
// - 0x1A[2:0] top-off time five minutes per code
// - 0x1B[7:5] die temp 60C+10C/code, saturates 100C
// - 0x1B[4:0] system voltage 4.1V+25mV/code, clamps 4.8V
module charger_config_regs #(
	parameter logic [6:0] ADDR_BASE = 7'h40 // Arbitrary value
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Address strap
	input wire logic addr_sel_i,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Charger settings
	output charger_cfg_pkg::charger_fields_t fields_o,
	output charger_cfg_pkg::charger_settings_t settings_o
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0] prechg_term;
	logic [7:0] therm_sysv;
	logic strap_done;
	logic [6:0] own_addr;
	logic scl_q;
	logic sda_q;
	charger_cfg_pkg::i2c_state_t state;
	charger_cfg_pkg::i2c_state_t next_state;
	charger_cfg_pkg::i2c_phase_t phase;
	charger_cfg_pkg::i2c_phase_t next_phase;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [7:0] ptr;
	logic [7:0] next_ptr;
	logic is_read;
	logic next_is_read;
	logic host_ack;
	logic next_host_ack;
	logic next_sda_oe;
	logic wr_en;
	charger_cfg_pkg::charger_fields_t fields;
	charger_cfg_pkg::charger_settings_t settings;

	// ************************************************************
	// Bus events and register select
	// ************************************************************
	wire start_seen = scl_i & scl_q & sda_q & ~sda_i;
	wire stop_seen = scl_i & scl_q & ~sda_q & sda_i;
	wire scl_rise = scl_i & ~scl_q;
	wire scl_fall = ~scl_i & scl_q;
	wire byte_done = bit_cnt == 4'h8;
	wire addr_match = shift[7:1] == own_addr;
	wire sel_prechg = ptr == charger_cfg_pkg::PRECHG_TERM_OFFSET;
	wire sel_therm = ptr == charger_cfg_pkg::THERM_SYSV_OFFSET;
	wire [7:0] rd_data = sel_prechg ? prechg_term
		: sel_therm ? therm_sysv : charger_cfg_pkg::UNMAPPED_READ;

	// ************************************************************
	// Address strap
	// ************************************************************
	// Strap sampled once after reset release, never under reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			strap_done <= 1'b0;
			own_addr <= ADDR_BASE;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			own_addr <= {ADDR_BASE[6:1], addr_sel_i};
		end
	end

	// ************************************************************
	// I2C target state machine
	// ************************************************************
	// Next-state logic; starts and stops override any state
	always_comb begin
		next_state = state;
		next_phase = phase;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_ptr = ptr;
		next_is_read = is_read;
		next_host_ack = host_ack;
		next_sda_oe = sda_oe_o;
		wr_en = 1'b0;
		if (start_seen) begin
			next_state = charger_cfg_pkg::ST_RX;
			next_phase = charger_cfg_pkg::PH_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_state = charger_cfg_pkg::ST_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				charger_cfg_pkg::ST_IDLE: begin
					next_sda_oe = 1'b0;
				end
				charger_cfg_pkg::ST_RX: begin
					if (scl_rise && !byte_done) begin
						next_shift = {shift[6:0], sda_i};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						next_state = charger_cfg_pkg::ST_ACK_OUT;
						next_sda_oe = 1'b1;
						case (phase)
							charger_cfg_pkg::PH_ADDR: begin
								next_is_read = shift[0];
								if (!addr_match) begin
									next_state = charger_cfg_pkg::ST_IDLE;
									next_sda_oe = 1'b0;
								end
							end
							charger_cfg_pkg::PH_PTR: begin
								next_ptr = shift;
							end
							default: begin
								wr_en = 1'b1;
								next_ptr = ptr + 8'h01;
							end
						endcase
					end
				end
				charger_cfg_pkg::ST_ACK_OUT: begin
					if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (is_read) begin
							// Pointer advances in the same cycle the byte is loaded from it
							next_state = charger_cfg_pkg::ST_TX;
							next_shift = rd_data;
							next_ptr = ptr + 8'h01;
							next_sda_oe = ~rd_data[7];
						end else begin
							next_state = charger_cfg_pkg::ST_RX;
							next_sda_oe = 1'b0;
							if (phase == charger_cfg_pkg::PH_ADDR) begin
								next_phase = charger_cfg_pkg::PH_PTR;
							end else begin
								next_phase = charger_cfg_pkg::PH_DATA;
							end
						end
					end
				end
				charger_cfg_pkg::ST_TX: begin
					if (scl_fall) begin
						next_bit_cnt = bit_cnt + 4'h1;
						next_shift = {shift[6:0], 1'b0};
						next_sda_oe = ~shift[6];
						if (bit_cnt == 4'h7) begin
							next_state = charger_cfg_pkg::ST_ACK_IN;
							next_sda_oe = 1'b0;
						end
					end
				end
				charger_cfg_pkg::ST_ACK_IN: begin
					// A host NACK ends the read; we wait for stop or start
					if (scl_rise) begin
						next_host_ack = ~sda_i;
					end else if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (host_ack) begin
							next_state = charger_cfg_pkg::ST_TX;
							next_shift = rd_data;
							next_ptr = ptr + 8'h01;
							next_sda_oe = ~rd_data[7];
						end else begin
							next_state = charger_cfg_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					next_state = charger_cfg_pkg::ST_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	// State and pin flip-flops
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state <= charger_cfg_pkg::ST_IDLE;
			phase <= charger_cfg_pkg::PH_ADDR;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			is_read <= 1'b0;
			host_ack <= 1'b0;
			sda_oe_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			state <= next_state;
			phase <= next_phase;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			ptr <= next_ptr;
			is_read <= next_is_read;
			host_ack <= next_host_ack;
			sda_oe_o <= next_sda_oe;
			sda_o <= 1'b0; // Open drain: only ever pulls low
		end
	end

	// ************************************************************
	// Register file
	// ************************************************************
	// Writes to unmapped offsets are acknowledged and dropped
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			prechg_term <= charger_cfg_pkg::PRECHG_TERM_RESET;
			therm_sysv <= charger_cfg_pkg::THERM_SYSV_RESET;
		end else if (wr_en && sel_prechg) begin
			prechg_term <= shift;
		end else if (wr_en && sel_therm) begin
			therm_sysv <= shift;
		end
	end

	// ************************************************************
	// Field decode
	// ************************************************************
	// Raw fields split from the stored bytes
	assign fields.prequal_voltage_sel = prechg_term[charger_cfg_pkg::PREQUAL_LSB +: 3];
	assign fields.term_sel = prechg_term[charger_cfg_pkg::TERM_LSB +: 2];
	assign fields.topoff_sel = prechg_term[charger_cfg_pkg::TOPOFF_LSB +: 3];
	assign fields.die_temp_regulation_sel = therm_sysv[charger_cfg_pkg::DIE_TEMP_LSB +: 3];
	assign fields.system_voltage_target = therm_sysv[charger_cfg_pkg::SYSV_LSB +: 5];

	// Decoded settings for the analog charger
	charger_field_decode u_decode (
		.fields_i(fields),
		.settings_o(settings)
	);

	// Registered outputs lag the stored bytes by one cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			fields_o <= '0;
			settings_o <= '0;
		end else begin
			fields_o <= fields;
			settings_o <= settings;
		end
	end

endmodule : charger_config_regs

// >>> verification/charger_config_regs_monitor.sv
// Checker on the register bank ports
`timescale 1ns/1ps
module charger_config_regs_monitor (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Settings
	input wire charger_cfg_pkg::charger_fields_t fields_o,
	input wire charger_cfg_pkg::charger_settings_t settings_o
);
	localparam logic [7:0] TERM_TAB [4] = '{8'h32, 8'h4B, 8'h64, 8'h96};
	// Outputs read zero on the first edge after reset, so wait that out
	logic [1:0] up;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i || up != 2'h3);
	// ******
	// Decode and pin checks
	// ******
	prequal_map_a: assert property (
		settings_o.prequal_mv == 12'h08FC + 12'h0064 * fields_o.prequal_voltage_sel)
		else $error("prequal decode wrong");
	term_map_a: assert property (
		settings_o.term_pct_x10 == TERM_TAB[fields_o.term_sel])
		else $error("termination decode wrong");
	topoff_map_a: assert property (
		settings_o.topoff_min == 6'h05 * fields_o.topoff_sel)
		else $error("topoff decode wrong");
	die_temp_map_a: assert property (
		settings_o.die_temp_c == (fields_o.die_temp_regulation_sel > 3'h3 ? 7'h64 :
		7'h3C + 7'h0A * fields_o.die_temp_regulation_sel))
		else $error("die temperature decode wrong");
	sysv_map_a: assert property (
		settings_o.sysv_mv == (fields_o.system_voltage_target > 5'h1B ? 13'h12C0 :
		13'h1004 + 13'h0019 * fields_o.system_voltage_target))
		else $error("system voltage decode wrong");
	// Defaults must appear on the second edge after release
	reset_values_a: assert property (disable iff (!rst_n_i)
		$rose(rst_n_i) |=> fields_o == 16'hF810)
		else $error("reset values wrong");
	released_reset_a: assert property (disable iff (1'b0)
		!rst_n_i |=> !sda_oe_o)
		else $error("data line held in reset");
	sda_low_a: assert property (sda_o == 1'b0)
		else $error("data drive level not low");
	ack_steady_a: assert property (
		scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe_o))
		else $error("data line moved while clock high");
	fields_quiet_a: assert property ($changed(fields_o) |-> !scl_i)
		else $error("settings moved outside a write");
	cover property (sda_oe_o);
	cover property (fields_o.system_voltage_target == 5'h1F);
	cover property (fields_o.die_temp_regulation_sel == 3'h4);
endmodule : charger_config_regs_monitor

// >>> verification/i2c_ctrl_model.sv
// Bus controller model driving the register bank pins
`timescale 1ns/1ps
module i2c_ctrl_model (
	// Clock
	input wire logic clk_i,
	// Resolved data line
	input wire logic sda_i,
	// Driven levels, high means released
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// ******
	// Pin sequencing
	// ******
	task automatic hp(input int n);
		repeat (n) @(negedge clk_i);
	endtask : hp
	// Data moves mid-low so the target never sees it near a clock edge
	task automatic bit_x(input logic b, output logic r);
		hp(3);
		sda_o = b;
		hp(5);
		scl_o = 1'b1;
		hp(4);
		r = sda_i;
		hp(4);
		scl_o = 1'b0;
	endtask : bit_x
	// Start when s is high, stop otherwise
	task automatic cond(input logic s);
		hp(3);
		sda_o = s;
		hp(5);
		scl_o = 1'b1;
		hp(6);
		sda_o = !s;
		hp(6);
		if (s) scl_o = 1'b0;
	endtask : cond
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(a, n);
	endtask : xfer
	// Pointer then two data bytes; nak gathers every refusal
	task automatic wr(input logic [7:0] adr, p, input logic [15:0] d, output logic nak);
		logic [7:0] q;
		logic [3:0] n;
		cond(1'b1);
		xfer(adr, 1'b1, q, n[3]);
		xfer(p, 1'b1, q, n[2]);
		xfer(d[15:8], 1'b1, q, n[1]);
		xfer(d[7:0], 1'b1, q, n[0]);
		cond(1'b0);
		nak = |n;
	endtask : wr
	// Pointer, repeated start, two bytes ending in a refusal
	task automatic rd(input logic [7:0] adr, p, output logic [15:0] d, output logic nak);
		logic [7:0] q;
		logic [2:0] n;
		logic z;
		cond(1'b1);
		xfer(adr, 1'b1, q, n[2]);
		xfer(p, 1'b1, q, n[1]);
		cond(1'b1);
		xfer(adr | 8'h01, 1'b1, q, n[0]);
		xfer(8'hFF, 1'b0, d[15:8], z);
		xfer(8'hFF, 1'b1, d[7:0], z);
		cond(1'b0);
		nak = |n;
	endtask : rd
endmodule : i2c_ctrl_model

// >>> verification/charger_config_regs_bench.sv
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
module charger_config_regs_bench;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic addr_sel_i = 1'b1;
	logic scl, drv, sda_o, sda_oe_o, nak;
	wire logic sda = sda_oe_o ? 1'b0 : drv; // Pull-up when nobody pulls
	charger_cfg_pkg::charger_fields_t fields_o;
	charger_cfg_pkg::charger_settings_t settings_o, es;
	logic [15:0] q;
	int n_fail = 0;
	int n_checks = 0;
	localparam logic [7:0] AW = 8'h82; // Strap high, write
	always #2.5 sys_clk_i = ~sys_clk_i;
	charger_config_regs dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.addr_sel_i(addr_sel_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .fields_o(fields_o), .settings_o(settings_o));
	i2c_ctrl_model ctrl_u (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(drv));
	// ******
	// Checks
	// ******
	task automatic chk(input logic [63:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Expected decode worked out from the raw bytes
	task automatic chk_set(input logic [15:0] v);
		logic [7:0] tt [4];
		tt = '{8'h32, 8'h4B, 8'h64, 8'h96};
		es.prequal_mv = 12'h08FC + 12'h0064 * v[15:13];
		es.term_pct_x10 = tt[v[12:11]];
		es.topoff_min = 6'h05 * v[10:8];
		es.die_temp_c = v[7:5] > 3'h3 ? 7'h64 : 7'h3C + 7'h0A * v[7:5];
		es.sysv_mv = v[4:0] > 5'h1B ? 13'h12C0 : 13'h1004 + 13'h0019 * v[4:0];
		chk(settings_o, es);
		chk(fields_o, v);
	endtask : chk_set
	task automatic wrrd(input logic [15:0] v);
		ctrl_u.wr(AW, 8'h1A, v, nak);
		chk(nak, 1'b0);
		ctrl_u.rd(AW, 8'h1A, q, nak);
		chk({nak, q}, {1'b0, v});
		chk_set(v);
	endtask : wrrd
	task automatic do_reset(input logic s);
		rst_n_i = 1'b0;
		addr_sel_i = s;
		repeat (12) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
	endtask : do_reset
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// Main sequence
	initial begin
		do_reset(1'b1);
		ctrl_u.rd(AW, 8'h1A, q, nak);
		chk(q, 16'hF810);
		chk_set(16'hF810);
		// Every code of the 3-bit and 2-bit fields; system voltage crosses its clamp
		for (int i = 0; i < 8; i++) begin
			wrrd({i[2:0], i[1:0], ~i[2:0], i[2:0], 5'h1B + 5'(i)});
		end
		// Bytes outside the bank are dropped and read zero
		ctrl_u.wr(AW, 8'h19, 16'hA5C3, nak);
		ctrl_u.wr(AW, 8'h1B, 16'h9F77, nak); // Clamped voltage keeps headroom
		ctrl_u.rd(AW, 8'h19, q, nak);
		chk(q, 16'h00C3);
		ctrl_u.rd(AW, 8'h1B, q, nak);
		chk(q, 16'h9F00);
		// Foreign address is refused and changes nothing
		ctrl_u.wr(8'h80, 8'h1A, 16'h0000, nak);
		chk(nak, 1'b1);
		chk_set(16'hC39F);
		// Second reset with the strap low moves the address
		do_reset(1'b0);
		ctrl_u.rd(8'h80, 8'h1A, q, nak);
		chk({nak, q}, 17'h0F810);
		ctrl_u.wr(AW, 8'h1A, 16'h0000, nak);
		chk(nak, 1'b1);
		print_verdict();
	end
endmodule : charger_config_regs_bench

bind charger_config_regs charger_config_regs_monitor mon_u (.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.fields_o(fields_o), .settings_o(settings_o));
